/* File: env_access.sv */
// Design decisions made here: strobed register access and the placing of the registers.
`timescale 1ns/1ns
module env_access #(
   parameter int BASE_CYCLES = env_pkg::BASE_CYCLES
) (
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic [3:0]  addr,
   input  wire logic [7:0]  wdata,
   input  wire logic        wr,
   input  wire logic        rd,
   output logic      [7:0]  rdata,
   output logic             busy
);

   // ==========================================================
   // Registers
   // ==========================================================
   logic [4:0]       word_address;
   logic [14:0]      word_data [4];
   logic [7:0]       nv_operation_control;
   env_pkg::env_op_e op;
   logic [31:0]      timer;
   logic             start;
   logic [3:0]       dsel;

   env_store_if sif ();

   env_store u_store (
      .clk   (clk),
      .reset (reset),
      .bus   (sif.store)
   );

   // Which data register an offset names: index in [1:0], high half in [3].
   function automatic logic [3:0] data_sel(input logic [3:0] a);
      logic [3:0] k;
      k = a - env_pkg::OFS_WORD0_LOW;
      return {k[0], 1'b0, k[2:1]};
   endfunction

   function automatic logic is_data(input logic [3:0] a);
      return a >= env_pkg::OFS_WORD0_LOW && a <= env_pkg::OFS_WORD3_HIGH;
   endfunction

   // Erase/write duration: the base time doubled per select step.
   function automatic logic [31:0] op_cycles(input logic [1:0] sel);
      return 32'(BASE_CYCLES) << sel;
   endfunction

   // A function result cannot be sliced, so the decode is kept in a net.
   assign dsel = data_sel(addr);

   // ==========================================================
   // Address register
   // ==========================================================
   always_ff @(posedge clk) begin
      if (reset) begin
         word_address <= 5'h00;
      end else if (wr && addr == env_pkg::OFS_WORD_ADDRESS && !busy) begin
         word_address <= wdata[4:0];
      end
   end

   // ==========================================================
   // Data registers
   // ==========================================================
   always_ff @(posedge clk) begin
      if (reset) begin
         for (int i = 0; i < 4; i++) begin
            word_data[i] <= 15'h0000;
         end
      end else if (busy && sif.done && op == env_pkg::ENV_OP_FETCH) begin
         word_data[0] <= sif.rdata;
      end else if (wr && is_data(addr) && !busy) begin
         if (dsel[3]) begin
            word_data[dsel[1:0]][14:8] <= wdata[6:0];
         end else begin
            word_data[dsel[1:0]][7:0] <= wdata;
         end
      end
   end

   // ==========================================================
   // Control register and sequencer
   // ==========================================================
   // A trigger starts an operation only when its enable was set by an
   // earlier write, so one stray write cannot start an erase or write; the fetch enable stays set after a fetch. Erase wins
   // over write and write over read; a trigger that loses is dropped.
   logic             ctl_write;
   logic             wipe_go;
   logic             prog_go;
   logic             fetch_go;
   logic             finish;
   logic [7:0]       next_ctl;
   env_pkg::env_op_e next_op;
   logic [31:0]      next_timer;

   always_comb begin
      ctl_write = wr && addr == env_pkg::OFS_CONTROL && !busy;
      wipe_go   = ctl_write && wdata[env_pkg::CTL_WIPE_GO]
                  && nv_operation_control[env_pkg::CTL_WIPE_EN];
      prog_go   = ctl_write && wdata[env_pkg::CTL_PROG_GO]
                  && nv_operation_control[env_pkg::CTL_PROG_EN]
                  && !wipe_go;
      fetch_go  = ctl_write && wdata[env_pkg::CTL_FETCH_GO]
                  && nv_operation_control[env_pkg::CTL_FETCH_EN]
                  && !wipe_go && !prog_go;
      start     = wipe_go || prog_go || fetch_go;
      next_ctl                        = wdata;
      next_ctl[env_pkg::CTL_WIPE_GO]  = wipe_go;
      next_ctl[env_pkg::CTL_PROG_GO]  = prog_go;
      next_ctl[env_pkg::CTL_FETCH_GO] = fetch_go;
      if (wipe_go) begin
         next_op    = env_pkg::ENV_OP_WIPE;
         next_timer = op_cycles(wdata[7:6]);
      end else if (prog_go) begin
         next_op    = env_pkg::ENV_OP_PROG;
         next_timer = op_cycles(wdata[7:6]);
      end else if (fetch_go) begin
         next_op    = env_pkg::ENV_OP_FETCH;
         next_timer = 32'(env_pkg::FETCH_CYCLES);
      end else begin
         next_op    = env_pkg::ENV_OP_NONE;
         next_timer = 32'h00000000;
      end
   end

   // The cycle ends on the array's answer once the timer has run out.
   assign finish = busy && timer == 32'h00000000 && sif.done;

   always_ff @(posedge clk) begin
      if (reset) begin
         nv_operation_control <= 8'h00;
      end else if (finish) begin
         unique case (op)
            env_pkg::ENV_OP_WIPE: begin
               nv_operation_control[env_pkg::CTL_WIPE_EN] <= 1'b0;
               nv_operation_control[env_pkg::CTL_WIPE_GO] <= 1'b0;
            end
            env_pkg::ENV_OP_PROG: begin
               nv_operation_control[env_pkg::CTL_PROG_EN] <= 1'b0;
               nv_operation_control[env_pkg::CTL_PROG_GO] <= 1'b0;
            end
            env_pkg::ENV_OP_FETCH: begin
               nv_operation_control[env_pkg::CTL_FETCH_GO] <= 1'b0;
            end
            env_pkg::ENV_OP_NONE: begin
            end
         endcase
      end else if (ctl_write) begin
         nv_operation_control <= next_ctl;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         op <= env_pkg::ENV_OP_NONE;
      end else if (finish) begin
         op <= env_pkg::ENV_OP_NONE;
      end else if (start) begin
         op <= next_op;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         busy <= 1'b0;
      end else if (finish) begin
         busy <= 1'b0;
      end else if (start) begin
         busy <= 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         timer <= 32'h00000000;
      end else if (start) begin
         timer <= next_timer;
      end else if (busy && timer != 32'h00000000) begin
         timer <= timer - 32'h00000001;
      end
   end

   // The array acts once, at the end of the timed cycle, so a reset
   // mid-operation leaves the old contents intact.
   always_ff @(posedge clk) begin
      if (reset) begin
         sif.start <= 1'b0;
      end else begin
         sif.start <= busy && timer == 32'h00000001;
      end
   end

   assign sif.op    = op;
   assign sif.addr  = word_address;
   assign sif.wdata = {word_data[3], word_data[2],
                       word_data[1], word_data[0]};

   // ==========================================================
   // Read port
   // ==========================================================
   always_ff @(posedge clk) begin
      if (reset) begin
         rdata <= env_pkg::RST_BYTE;
      end else if (rd) begin
         if (addr == env_pkg::OFS_WORD_ADDRESS) begin
            rdata <= {3'b000, word_address};
         end else if (addr == env_pkg::OFS_CONTROL) begin
            rdata <= nv_operation_control;
         end else if (is_data(addr)) begin
            if (dsel[3]) begin
               rdata <= {1'b0, word_data[dsel[1:0]][14:8]};
            end else begin
               rdata <= word_data[dsel[1:0]][7:0];
            end
         end else begin
            rdata <= env_pkg::RST_BYTE;
         end
      end else begin
         rdata <= env_pkg::RST_BYTE;
      end
   end

endmodule

/* File: env_pkg.sv */
package env_pkg;

   // ==========================================================
   // Register map (byte-wide registers, index addressing)
   // ==========================================================
   localparam int          ADDR_W          = 4;
   localparam int          DATA_W          = 8;
   localparam logic [3:0]  OFS_WORD_ADDRESS = 4'h0;
   localparam logic [3:0]  OFS_WORD0_LOW    = 4'h1;
   localparam logic [3:0]  OFS_WORD0_HIGH   = 4'h2;
   localparam logic [3:0]  OFS_WORD1_LOW    = 4'h3;
   localparam logic [3:0]  OFS_WORD1_HIGH   = 4'h4;
   localparam logic [3:0]  OFS_WORD2_LOW    = 4'h5;
   localparam logic [3:0]  OFS_WORD2_HIGH   = 4'h6;
   localparam logic [3:0]  OFS_WORD3_LOW    = 4'h7;
   localparam logic [3:0]  OFS_WORD3_HIGH   = 4'h8;
   localparam logic [3:0]  OFS_CONTROL      = 4'h9;

   // ==========================================================
   // Storage geometry
   // ==========================================================
   localparam int          WORDS           = 32;
   localparam int          WORD_W          = 15;
   localparam int          WADDR_W         = 5;
   localparam int          UNIT_WORDS      = 4;
   localparam logic [7:0]  RST_BYTE        = 8'h00;
   localparam logic [14:0] ERASED_WORD     = 15'h0000;

   // ==========================================================
   // Control register fields
   // ==========================================================
   localparam int          CTL_TIME_HI     = 7;
   localparam int          CTL_TIME_LO     = 6;
   localparam int          CTL_WIPE_EN     = 5;
   localparam int          CTL_WIPE_GO     = 4;
   localparam int          CTL_PROG_EN     = 3;
   localparam int          CTL_PROG_GO     = 2;
   localparam int          CTL_FETCH_EN    = 1;
   localparam int          CTL_FETCH_GO    = 0;

   // ==========================================================
   // Timing
   // ==========================================================
   localparam int          CLK_HZ          = 20_000_000;
   localparam int          BASE_TIME_MS    = 2;
   localparam int          BASE_CYCLES     = CLK_HZ / 1000 * BASE_TIME_MS;
   localparam int          FETCH_CYCLES    = 1;

   typedef enum logic [1:0] {
      ENV_OP_NONE  = 2'b00,
      ENV_OP_WIPE  = 2'b01,
      ENV_OP_PROG  = 2'b10,
      ENV_OP_FETCH = 2'b11
   } env_op_e;

endpackage

/* File: env_store_if.sv */
`timescale 1ns/1ns
interface env_store_if;
   logic                  start;
   env_pkg::env_op_e      op;
   logic [4:0]            addr;
   logic [59:0]           wdata;
   logic                  done;
   logic [14:0]           rdata;

   modport ctrl (output start, output op, output addr, output wdata,
                 input done, input rdata);
   modport store (input start, input op, input addr, input wdata,
                  output done, output rdata);
endinterface

/* File: env_store.sv */
`timescale 1ns/1ns
module env_store (
   input  wire logic clk,
   input  wire logic reset,
   env_store_if.store bus
);

   // ==========================================================
   // Array
   // ==========================================================
   // Contents are non-volatile, so reset leaves the array alone.
   logic [14:0] mem [32];
   logic [4:0]  base;
   logic        go;

   assign base = bus.addr;
   assign go   = bus.start;

   always_ff @(posedge clk) begin
      if (go && bus.op == env_pkg::ENV_OP_WIPE) begin
         for (int i = 0; i < 16; i++) begin
            mem[{base[4], 4'(i)}] <= env_pkg::ERASED_WORD;
         end
      end else if (go && bus.op == env_pkg::ENV_OP_PROG) begin
         for (int i = 0; i < 4; i++) begin
            mem[{base[4:2], 2'(i)}] <= bus.wdata[i*15 +: 15];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         bus.rdata <= env_pkg::ERASED_WORD;
      end else if (go && bus.op == env_pkg::ENV_OP_FETCH) begin
         bus.rdata <= mem[base];
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         bus.done <= 1'b0;
      end else begin
         bus.done <= go;
      end
   end

endmodule

/* File: env_access_assertions.sv */
`timescale 1ns/1ns
module env_access_assertions #(
   parameter int BASE_CYCLES = 4
) (
   input  wire logic       clk,
   input  wire logic       reset,
   input  wire logic [3:0] addr,
   input  wire logic [7:0] wdata,
   input  wire logic       wr,
   input  wire logic       rd,
   input  wire logic [7:0] rdata,
   input  wire logic       busy
);
   // ==========================================================
   // Busy length counter
   // ==========================================================
   // A counter keeps the longest cycle check cheap for the tools.
   logic [31:0] busy_run;
   always_ff @(posedge clk) begin
      if (reset || !busy)
         busy_run <= 32'h0;
      else
         busy_run <= busy_run + 32'h1;
   end

   default clocking @(posedge clk); endclocking
   default disable iff (reset);

   a_rdata_idle: assert property (
      !$past(rd) |-> rdata == 8'h00)
      else $error("read data not zero outside a read answer");
   a_addr_top_zero: assert property (
      $past(rd) && $past(addr) == env_pkg::OFS_WORD_ADDRESS
      |-> rdata[7:5] == 3'h0)
      else $error("address register upper bits not zero");
   a_high_bit7: assert property (
      $past(rd) && $past(addr) inside {4'h2, 4'h4, 4'h6, 4'h8}
      |-> rdata[7] == 1'b0)
      else $error("high data register bit 7 not zero");
   a_unmapped_zero: assert property (
      $past(rd) && $past(addr) > 4'h9 |-> rdata == 8'h00)
      else $error("unmapped index read not zero");
   a_busy_cause: assert property (
      $rose(busy) |-> $past(wr) && $past(addr) == env_pkg::OFS_CONTROL)
      else $error("busy rose without a control write");
   a_busy_min: assert property (
      $rose(busy) |-> busy ##1 busy)
      else $error("busy shorter than two cycles");
   a_busy_bound: assert property (
      busy_run <= (BASE_CYCLES << 3) + 2)
      else $error("busy longer than the longest cycle");
   a_word_hold: assert property (
      (wr && addr == env_pkg::OFS_WORD0_LOW && !busy) ##2
      (rd && addr == env_pkg::OFS_WORD0_LOW && !busy)
      |=> rdata == $past(wdata, 3))
      else $error("data register did not hold written value");
endmodule

bind env_access env_access_assertions #(.BASE_CYCLES(BASE_CYCLES)) u_chk (
   .clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr),
   .rd(rd), .rdata(rdata), .busy(busy));

/* File: env_access_bench.sv */
`timescale 1ns/1ns
module env_access_bench;
   localparam int BASE = 4;
   logic       clk   = 1'b0;
   logic       reset = 1'b1;
   logic [3:0] addr  = 4'h0;
   logic [7:0] wdata = 8'h00;
   logic       wr    = 1'b0;
   logic       rd    = 1'b0;
   logic [7:0] rdata;
   logic       busy;
   int         n_mismatch   = 0;
   int         total_checks = 0;
   int         n;

   always #25 clk = ~clk;

   env_access #(.BASE_CYCLES(BASE)) DUT (.clk(clk), .reset(reset),
      .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .busy(busy));

   // ==========================================================
   // Access tasks
   // ==========================================================
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wreg(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   task automatic rreg(input logic [3:0] a, input logic [7:0] exp);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1 check(rdata, exp);
   endtask

   // Counts busy cycles from the edge that took the trigger on; gives up
   // after 300 so a hung cycle cannot stall the run.
   task automatic wait_idle;
      int k;
      n = 0;
      k = 0;
      #1;
      while (busy !== 1'b0 && k < 300) begin
         n++;
         @(posedge clk);
         #1;
         k++;
      end
   endtask

   task automatic op(input logic [7:0] en, input logic [7:0] go);
      wreg(env_pkg::OFS_CONTROL, en);
      wreg(env_pkg::OFS_CONTROL, go);
      wait_idle();
   endtask

   task automatic fetch(input logic [4:0] w, input logic [14:0] exp);
      wreg(env_pkg::OFS_WORD_ADDRESS, {3'h0, w});
      op(8'h02, 8'h03);
      rreg(env_pkg::OFS_CONTROL, 8'h02);
      rreg(env_pkg::OFS_WORD0_LOW, exp[7:0]);
      rreg(env_pkg::OFS_WORD0_HIGH, {1'b0, exp[14:8]});
   endtask

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // ==========================================================
   // Tests
   // ==========================================================
   initial begin
      repeat (10) @(posedge clk);
      reset <= 1'b0;
      for (int i = 0; i < 16; i++)
         rreg(i[3:0], 8'h00);
      $display("done: reset values");
      for (int i = 0; i <= 8; i++) begin
         wreg(i[3:0], 8'hFF);
         rreg(i[3:0], i == 0 ? 8'h1F : (i[0] ? 8'hFF : 8'h7F));
      end
      wreg(4'hC, 8'hFF);
      rreg(4'hC, 8'h00);
      $display("done: register masks");
      for (int i = 0; i < 3; i++) begin
         op(8'h00, 8'h01 << (2 * i));
         check(n[7:0], 8'h00);
         rreg(env_pkg::OFS_CONTROL, 8'h00);
      end
      $display("done: trigger without enable");
      for (int s = 0; s < 4; s++) begin
         wreg(env_pkg::OFS_WORD_ADDRESS, s[0] ? 8'h13 : 8'h0C);
         op({s[1:0], 6'h20}, {s[1:0], 6'h30});
         check(n[7:0], 8'((BASE << s) + 2));
         rreg(env_pkg::OFS_CONTROL, {s[1:0], 6'h00});
      end
      $display("done: erase durations");
      wreg(env_pkg::OFS_WORD_ADDRESS, 8'h19);
      for (int i = 0; i < 4; i++) begin
         wreg(4'(2 * i + 1), i[7:0] + 8'hA0);
         wreg(4'(2 * i + 2), i[7:0] + 8'h50);
      end
      op(8'h08, 8'h0C);
      check(n[7:0], 8'(BASE + 2));
      rreg(env_pkg::OFS_CONTROL, 8'h00);
      for (int i = 0; i < 4; i++)
         fetch(5'(24 + i), {i[6:0] + 7'h50, i[7:0] + 8'hA0});
      fetch(5'd28, 15'h0000);
      fetch(5'd23, 15'h0000);
      $display("done: unit write and fetch");
      wreg(env_pkg::OFS_WORD_ADDRESS, 8'h0F);
      wreg(env_pkg::OFS_CONTROL, 8'h20);
      wreg(env_pkg::OFS_CONTROL, 8'h30);
      wreg(env_pkg::OFS_WORD_ADDRESS, 8'h05);
      wait_idle();
      rreg(env_pkg::OFS_WORD_ADDRESS, 8'h0F);
      fetch(5'd24, 15'h50A0);
      wreg(env_pkg::OFS_WORD_ADDRESS, 8'h13);
      op(8'h20, 8'h30);
      fetch(5'd27, 15'h0000);
      $display("done: page erase");
      wrap_up();
   end

   initial begin
      #(50 * 20000);
      n_mismatch++;
      $display("[ERR] %0t watchdog expired", $time);
      wrap_up();
   end
endmodule
